// File: core/dsc_clock_reset.sv
// dual speed clock source with power-on reset supervisor
// How it works
// - disabling stops clock at its next rising edge
// - clock parks high while disabled
// - reset asserted while disabled, per polarity
// - speed low picks slow, high picks fast
// - source changes only between whole phases
// - reset held power-on delay after rising trip
// - clock starts before reset releases
// - brownout asserts reset, then fresh delay
// - rise at rising point, fall at falling point
// - short supply dips are filtered out
// - reset stage fixed: low, high or open-drain
`timescale 1ns/1ns
module dsc_clock_reset
	import dsc_pkg::*;
#(
	parameter int unsigned FAST_HALF = dsc_pkg::FAST_HALF_CYC,
	parameter int unsigned SLOW_HALF = dsc_pkg::SLOW_HALF_CYC,
	parameter int unsigned POR_CYCLES = dsc_pkg::POR_CYC,
	parameter int unsigned START_CYCLES = dsc_pkg::OSC_START_CYC,
	parameter int unsigned DIP_CYCLES = dsc_pkg::DIP_CYC,
	parameter bit TRIP_HIGH_OPT = 1'b0,
	parameter bit SPEED_RST = 1'b1,
	parameter dsc_pkg::dsc_rst_mode_t RST_MODE = dsc_pkg::RST_LOW_PP
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// supply comparators
	input wire logic supply_above_rise,
	input wire logic supply_below_fall,
	// avalon-mm slave
	input wire logic [dsc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// clock and reset outputs
	output logic clk_out,
	output logic rst_out,
	output logic rst_oe
);
	import dsc_pkg::*;

	if (FAST_HALF < 1 || FAST_HALF > 65535 || SLOW_HALF < 1 || SLOW_HALF > 65535) begin : g_bad_half
		$error("half period out of range");
	end
	if (POR_CYCLES < 1 || START_CYCLES < 1 || DIP_CYCLES < 1) begin : g_bad_cyc
		$error("timer counts must be at least one");
	end

	localparam logic [15:0] FAST_LD = 16'(FAST_HALF - 1);
	localparam logic [15:0] SLOW_LD = 16'(SLOW_HALF - 1);
	localparam logic [15:0] RISE_MV = TRIP_HIGH_OPT ? RISE_HI_MV : RISE_LO_MV;
	localparam logic [15:0] FALL_MV = TRIP_HIGH_OPT ? FALL_HI_MV : FALL_LO_MV;
	localparam logic RST_OUT_INIT = (RST_MODE == RST_HIGH_PP);
	localparam logic RST_OE_INIT = 1'b1;

	function automatic logic [15:0] half_load(input logic fast);
		return fast ? FAST_LD : SLOW_LD;
	endfunction

	// bus and control state
	logic wait_r;
	logic wait_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic ctrl_en_r;
	logic ctrl_en_nxt;
	logic ctrl_speed_r;
	logic ctrl_speed_nxt;
	// oscillator state
	logic osc_on_r;
	logic osc_on_nxt;
	logic clk_out_r;
	logic clk_nxt;
	logic [15:0] ph_cnt_r;
	logic [15:0] ph_nxt;
	logic src_fast_r;
	logic src_nxt;
	logic parked_r;
	logic park_nxt;
	// supervisor and reset pin state
	dsc_sup_t sup_r;
	dsc_sup_t sup_nxt;
	logic rst_act_r;
	logic rst_act_nxt;
	logic rst_out_r;
	logic rst_out_nxt;
	logic rst_oe_r;
	logic rst_oe_nxt;

	logic start_done;
	logic por_done;
	logic dip_tmr_done;
	logic dip_done;
	logic [31:0] status_word;
	logic [31:0] trip_word;
	logic req;

	// oscillator warm-up after power-up
	dsc_timer #(.LIMIT(START_CYCLES - 1)) u_start_tmr (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clr(1'b0),
		.en(!osc_on_r),
		.done(start_done)
	);

	// power-on delay, restarts whenever the delay state is left
	dsc_timer #(.LIMIT(POR_CYCLES - 1)) u_por_tmr (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clr(sup_r != SUP_DELAY),
		.en(1'b1),
		.done(por_done)
	);

	// undervoltage must persist before it counts
	dsc_timer #(.LIMIT(DIP_CYCLES - 1)) u_dip_tmr (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clr(!supply_below_fall),
		.en(1'b1),
		.done(dip_tmr_done)
	);

	assign dip_done = dip_tmr_done && supply_below_fall;

	// register bus: one wait cycle, then a one-cycle answer
	assign req = avs_read || avs_write;

	always_comb begin
		status_word = RDATA_ZERO;
		status_word[STAT_SUP_GOOD_BIT] = (sup_r == SUP_GOOD);
		status_word[STAT_RST_ACT_BIT] = rst_act_r;
		status_word[STAT_OSC_ON_BIT] = osc_on_r;
		status_word[STAT_SRC_FAST_BIT] = src_fast_r;
		status_word[STAT_PARKED_BIT] = parked_r;
		status_word[STAT_CLK_BIT] = clk_out_r;
		trip_word = RDATA_ZERO;
		trip_word[TRIP_RISE_LSB +: 16] = RISE_MV;
		trip_word[TRIP_FALL_LSB +: 16] = FALL_MV;
	end

	always_comb begin
		wait_nxt = !(req && wait_r);
		rdata_nxt = rdata_r;
		ctrl_en_nxt = ctrl_en_r;
		ctrl_speed_nxt = ctrl_speed_r;
		if (avs_read && wait_r) begin
			unique case (avs_address)
				REG_CTRL: begin
					rdata_nxt = RDATA_ZERO;
					rdata_nxt[CTRL_EN_BIT] = ctrl_en_r;
					rdata_nxt[CTRL_SPEED_BIT] = ctrl_speed_r;
				end
				REG_STATUS: rdata_nxt = status_word;
				REG_TRIP: rdata_nxt = trip_word;
				default: rdata_nxt = RDATA_ZERO;
			endcase
		end
		if (avs_write && !wait_r && (avs_address == REG_CTRL) && avs_byteenable[0]) begin
			ctrl_en_nxt = avs_writedata[CTRL_EN_BIT];
			ctrl_speed_nxt = avs_writedata[CTRL_SPEED_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_r <= 1'b1;
			rdata_r <= RDATA_ZERO;
			ctrl_en_r <= CTRL_EN_RST;
			ctrl_speed_r <= SPEED_RST;
		end else begin
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			ctrl_en_r <= ctrl_en_nxt;
			ctrl_speed_r <= ctrl_speed_nxt;
		end
	end

	// clock generator: each phase is a whole half period of one source
	always_comb begin
		osc_on_nxt = osc_on_r || start_done;
		clk_nxt = clk_out_r;
		ph_nxt = ph_cnt_r;
		src_nxt = src_fast_r;
		park_nxt = parked_r;
		if (!osc_on_r) begin
			ph_nxt = half_load(ctrl_speed_r);
			src_nxt = ctrl_speed_r;
		end else if (parked_r) begin
			if (ctrl_en_r) begin
				park_nxt = 1'b0;
				clk_nxt = 1'b0;
				src_nxt = ctrl_speed_r;
				ph_nxt = half_load(ctrl_speed_r);
			end
		end else if (ph_cnt_r != 16'h0000) begin
			ph_nxt = ph_cnt_r - 16'h0001;
		end else if (clk_out_r) begin
			clk_nxt = 1'b0;
			ph_nxt = half_load(src_fast_r);
		end else begin
			clk_nxt = 1'b1;
			src_nxt = ctrl_speed_r;
			ph_nxt = half_load(ctrl_speed_r);
			park_nxt = !ctrl_en_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			osc_on_r <= 1'b0;
			clk_out_r <= 1'b0;
			ph_cnt_r <= 16'h0000;
			src_fast_r <= 1'b0;
			parked_r <= 1'b0;
		end else begin
			osc_on_r <= osc_on_nxt;
			clk_out_r <= clk_nxt;
			ph_cnt_r <= ph_nxt;
			src_fast_r <= src_nxt;
			parked_r <= park_nxt;
		end
	end

	// supply supervisor with hysteresis
	always_comb begin
		sup_nxt = sup_r;
		unique case (sup_r)
			SUP_DOWN: begin
				if (supply_above_rise) begin
					sup_nxt = SUP_DELAY;
				end
			end
			SUP_DELAY: begin
				if (dip_done) begin
					sup_nxt = SUP_DOWN;
				end else if (por_done) begin
					sup_nxt = SUP_GOOD;
				end
			end
			SUP_GOOD: begin
				if (dip_done) begin
					sup_nxt = SUP_DOWN;
				end
			end
			default: sup_nxt = SUP_DOWN;
		endcase
	end

	// reset pin stage
	always_comb begin
		rst_act_nxt = (sup_r != SUP_GOOD) || !ctrl_en_r;
		unique case (RST_MODE)
			RST_LOW_PP: begin
				rst_out_nxt = !rst_act_nxt;
				rst_oe_nxt = 1'b1;
			end
			RST_HIGH_PP: begin
				rst_out_nxt = rst_act_nxt;
				rst_oe_nxt = 1'b1;
			end
			default: begin
				rst_out_nxt = 1'b0;
				rst_oe_nxt = rst_act_nxt;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sup_r <= SUP_DOWN;
			rst_act_r <= 1'b1;
			rst_out_r <= RST_OUT_INIT;
			rst_oe_r <= RST_OE_INIT;
		end else begin
			sup_r <= sup_nxt;
			rst_act_r <= rst_act_nxt;
			rst_out_r <= rst_out_nxt;
			rst_oe_r <= rst_oe_nxt;
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign clk_out = clk_out_r;
	assign rst_out = rst_out_r;
	assign rst_oe = rst_oe_r;

	// checking helpers
	logic [15:0] len_r;
	logic len_ok_r;
	logic [15:0] del_len_r;
	logic [15:0] dip_len_r;
	logic [15:0] cyc_r;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			len_r <= 16'h0000;
			len_ok_r <= 1'b0;
			del_len_r <= 16'h0000;
			dip_len_r <= 16'h0000;
			cyc_r <= 16'h0000;
		end else begin
			len_r <= (clk_nxt != clk_out_r) ? 16'h0000 : len_r + {15'h0000, len_r != 16'hffff};
			len_ok_r <= len_ok_r || (clk_nxt != clk_out_r);
			del_len_r <= (sup_r == SUP_DELAY) ? del_len_r + 16'h0001 : 16'h0000;
			dip_len_r <= supply_below_fall ? dip_len_r + {15'h0000, dip_len_r != 16'hffff} : 16'h0000;
			cyc_r <= cyc_r + {15'h0000, cyc_r != 16'hffff};
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	chk_stop_on_rise: assert property ($rose(parked_r) |-> $rose(clk_out_r) && !$past(ctrl_en_r))
		else $error("clock parked other than at a rising edge");
	chk_park_high: assert property (parked_r |-> clk_out_r && clk_out)
		else $error("clock not high while parked");
	chk_rst_when_off: assert property (!ctrl_en_r |=> rst_act_r)
		else $error("reset not asserted while disabled");
	chk_speed_route: assert property ($rose(clk_out_r) |-> src_fast_r == $past(ctrl_speed_r))
		else $error("clock source does not follow speed select");
	chk_whole_phase: assert property (
		$changed(clk_out_r) && $past(len_ok_r) && !$past(parked_r)
		|-> 16'($past(len_r) + 16'h0001) == 16'($past(src_fast_r) ? FAST_HALF : SLOW_HALF))
		else $error("clock phase shortened or stretched");
	chk_por_delay: assert property ($rose(sup_r == SUP_GOOD) |-> del_len_r == 16'(POR_CYCLES))
		else $error("power-on delay length wrong");
	chk_osc_start: assert property ($rose(osc_on_r) |-> cyc_r == 16'(START_CYCLES) && rst_act_r)
		else $error("oscillator start time wrong");
	chk_brownout_rst: assert property (
		(sup_r == SUP_GOOD) && dip_done |=> (sup_r == SUP_DOWN) ##1 rst_act_r)
		else $error("brownout did not assert reset");
	chk_rise_trip: assert property (
		(sup_r == SUP_DOWN) ##1 (sup_r == SUP_DELAY) |-> $past(supply_above_rise))
		else $error("delay started without rising trip");
	chk_dip_filter: assert property (
		$fell(sup_r == SUP_GOOD) |-> $past(dip_len_r) >= 16'(DIP_CYCLES - 1))
		else $error("short dip asserted reset");
	chk_pin_stage: assert property (
		rst_oe_r == ((RST_MODE == RST_LOW_OD) ? rst_act_r : 1'b1)
		&& rst_out_r == ((RST_MODE == RST_HIGH_PP) ? rst_act_r
		: ((RST_MODE == RST_LOW_PP) && !rst_act_r)))
		else $error("reset pin stage does not match variant");
	chk_unpark_low: assert property ($fell(parked_r) |-> !clk_out_r ##1 !clk_out_r)
		else $error("resume did not start with low phase");

	cov_park_resume: cover property ($rose(parked_r) ##[1:1000] $fell(parked_r));
	cov_speed_switch: cover property ($rose(clk_out_r) && $changed(src_fast_r));
	cov_brownout: cover property ($fell(sup_r == SUP_GOOD));
	cov_por_done: cover property ($rose(sup_r == SUP_GOOD));
endmodule // dsc_clock_reset

// File: core/dsc_pkg.sv
// constants and types for the dual speed clock and reset block
package dsc_pkg;
	// system clock
	localparam int unsigned SYS_CLK_HZ = 20_000_000;
	localparam int unsigned SYS_CLK_PERIOD_NS = 50;

	// reset hold after supply crosses the rising trip point
	localparam int unsigned POR_DELAY_NS = 100_000;
	localparam int unsigned POR_CYC = POR_DELAY_NS / SYS_CLK_PERIOD_NS;

	// oscillator start after power-up, longest time so rounded down
	localparam int unsigned OSC_START_NS = 30_000;
	localparam int unsigned OSC_START_CYC = OSC_START_NS / SYS_CLK_PERIOD_NS;

	// shortest supply dip that may assert reset, least time so rounded up
	localparam int unsigned DIP_REJECT_NS = 20_000;
	localparam int unsigned DIP_CYC = (DIP_REJECT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

	// oscillator half periods in system clock cycles
	localparam int unsigned SLOW_OSC_HZ = 32_768;
	localparam int unsigned SLOW_HALF_CYC = SYS_CLK_HZ / (2 * SLOW_OSC_HZ);
	localparam int unsigned FAST_OSC_HZ = 1_000_000;
	localparam int unsigned FAST_HALF_CYC = SYS_CLK_HZ / (2 * FAST_OSC_HZ);

	// trip points in millivolts, falling point derived from hysteresis percent
	localparam int unsigned TRIP_LO_OPT_MV = 2570;
	localparam int unsigned TRIP_HI_OPT_MV = 4290;
	localparam int unsigned HYST_PCT = 2;
	localparam logic [15:0] RISE_LO_MV = 16'(TRIP_LO_OPT_MV);
	localparam logic [15:0] RISE_HI_MV = 16'(TRIP_HI_OPT_MV);
	localparam logic [15:0] FALL_LO_MV = 16'(TRIP_LO_OPT_MV * 100 / (100 + HYST_PCT));
	localparam logic [15:0] FALL_HI_MV = 16'(TRIP_HI_OPT_MV * 100 / (100 + HYST_PCT));

	// register map, byte addresses
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_TRIP = 4'h8;

	// control fields
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_SPEED_BIT = 1;
	localparam logic CTRL_EN_RST = 1'b1;

	// status fields
	localparam int unsigned STAT_SUP_GOOD_BIT = 0;
	localparam int unsigned STAT_RST_ACT_BIT = 1;
	localparam int unsigned STAT_OSC_ON_BIT = 2;
	localparam int unsigned STAT_SRC_FAST_BIT = 3;
	localparam int unsigned STAT_PARKED_BIT = 4;
	localparam int unsigned STAT_CLK_BIT = 5;

	// trip register fields
	localparam int unsigned TRIP_RISE_LSB = 0;
	localparam int unsigned TRIP_FALL_LSB = 16;

	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	// supervisor states
	typedef enum logic [1:0] {
		SUP_DOWN,
		SUP_DELAY,
		SUP_GOOD
	} dsc_sup_t;

	// reset output stage variants
	typedef enum logic [1:0] {
		RST_LOW_PP,
		RST_HIGH_PP,
		RST_LOW_OD
	} dsc_rst_mode_t;
endpackage

// File: core/dsc_timer.sv
// saturating cycle timer with synchronous clear
`timescale 1ns/1ns
module dsc_timer #(
	parameter int unsigned LIMIT = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// control
	input wire logic clr,
	input wire logic en,
	// result
	output logic done
);
	localparam int unsigned W = (LIMIT < 2) ? 1 : $clog2(LIMIT + 1);
	localparam logic [W-1:0] LIM = W'(LIMIT);

	if (LIMIT >= 32'h0100_0000) begin : g_bad_limit
		$error("dsc_timer limit too large");
	end

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (clr) begin
			cnt_nxt = '0;
		end else if (en && (cnt_r != LIM)) begin
			cnt_nxt = cnt_r + W'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign done = (cnt_r == LIM);
endmodule // dsc_timer

// File: verification/dsc_clock_reset_tb.sv
// self-checking bench for the dual speed clock and reset block
`timescale 1ns/1ns
module dsc_clock_reset_tb;
	import dsc_pkg::*;
	localparam int FAST_H = 10;
	localparam int SLOW_H = 25;
	localparam int POR_C = 20;
	localparam int START_C = 6;
	localparam int DIP_C = 4;
	typedef struct {logic [31:0] ctrl; int half; logic fast;} dsc_row_t;

	logic sys_clk, rst_b, supply_above_rise, supply_below_fall, clr;
	logic [3:0] avs_address, avs_byteenable;
	logic avs_read, avs_write;
	logic [31:0] avs_writedata, rd;
	wire [31:0] rd_v [3];
	wire [2:0] wait_v, clk_v, rst_v, oe_v;
	logic [2:0] rst_w;
	int last_hi, last_lo, min_len, error_cnt, n_checks, c, n;
	time t0;
	dsc_row_t rows [3];

	// open-drain variant sees a pull-up when released
	assign rst_w = {oe_v[2] ? rst_v[2] : 1'b1, rst_v[1], rst_v[0]};

	for (genvar m = 0; m < 3; m++) begin : g_mode
		dsc_clock_reset #(.FAST_HALF(FAST_H), .SLOW_HALF(SLOW_H), .POR_CYCLES(POR_C),
			.START_CYCLES(START_C), .DIP_CYCLES(DIP_C), .TRIP_HIGH_OPT(m == 1),
			.RST_MODE(dsc_rst_mode_t'(m))
		) dsc_clock_reset_i (.sys_clk(sys_clk), .rst_b(rst_b),
			.supply_above_rise(supply_above_rise), .supply_below_fall(supply_below_fall),
			.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
			.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
			.avs_readdata(rd_v[m]), .avs_waitrequest(wait_v[m]),
			.clk_out(clk_v[m]), .rst_out(rst_v[m]), .rst_oe(oe_v[m]));
	end

	dsc_mcu_model dsc_mcu_model_i (.sys_clk(sys_clk), .clk_in(clk_v[0]), .clr(clr),
		.last_hi(last_hi), .last_lo(last_lo), .min_len(min_len));

	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;

	task fail(input string msg);
		error_cnt++;
		$display("[ERR] %0t %s", $time, msg);
	endtask

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
			fail($sformatf("word %h, expected %h", got, exp));
	endtask

	task chk_len(input int got, input int exp);
		n_checks++;
		if (got != exp)
			fail($sformatf("length %0d, expected %0d", got, exp));
	endtask

	task chk_rst(input logic asserted);
		logic [4:0] exp;
		exp = asserted ? 5'b11_010 : 5'b11_101;
		n_checks++;
		if ({oe_v[1:0], rst_w} !== exp)
			fail($sformatf("reset pins %b, expected %b", {oe_v[1:0], rst_w}, exp));
	endtask

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int k;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (wait_v[0] !== 1'b0 && k < 50);
		rd = rd_v[0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 50)
			fail("bus hang");
	endtask

	task wait_lvl(input logic v);
		int k;
		k = 0;
		while (clk_v[0] !== v && k < 4000) begin
			@(posedge sys_clk);
			k++;
		end
		if (k >= 4000)
			fail("clock stuck");
	endtask

	task wait_rise;
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		@(posedge sys_clk);
	endtask

	task wait_release;
		while (rst_w !== 3'b101 && $time - t0 < 50_000)
			@(posedge sys_clk);
		c = int'(($time - t0) / 50);
		chk_word(32'(c >= POR_C && c <= POR_C + 4), 32'h0000_0001);
	endtask

	task conclude;
		$display("checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		fail("timeout");
		conclude();
	end

	initial begin
		rows = '{'{32'h0000_0001, SLOW_H, 1'b0}, '{32'h0000_0003, FAST_H, 1'b1},
			'{32'h0000_0001, SLOW_H, 1'b0}};
		rst_b = 1'b0;
		supply_above_rise = 1'b1;
		supply_below_fall = 1'b0;
		clr = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
		error_cnt = 0;
		n_checks = 0;
		repeat (3) @(posedge sys_clk);
		chk_word({30'h0, wait_v[0], clk_v[0]}, 32'h0000_0002);
		chk_rst(1'b1);
		rst_b <= 1'b1;
		t0 = $time;
		wait_rise();
		chk_rst(1'b1);
		chk_word(32'(($time - t0) / 50 <= START_C + FAST_H + 4), 32'h0000_0001);
		wait_release();
		chk_rst(1'b0);
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		chk_word(rd, 32'h0000_0003);
		// write with byte 0 disabled must leave control alone
		avs_byteenable <= 4'he;
		bus(1'b1, REG_CTRL, 32'h0000_0000);
		avs_byteenable <= 4'hf;
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		chk_word(rd, 32'h0000_0003);
		bus(1'b1, REG_TRIP, 32'h0000_0000);
		bus(1'b0, REG_TRIP, 32'h0000_0000);
		chk_word(rd, {FALL_LO_MV, RISE_LO_MV});
		chk_word(rd_v[1], {FALL_HI_MV, RISE_HI_MV});
		bus(1'b0, 4'hc, 32'h0000_0000);
		chk_word(rd, RDATA_ZERO);
		foreach (rows[i]) begin
			clr <= 1'b1;
			bus(1'b1, REG_CTRL, rows[i].ctrl);
			clr <= 1'b0;
			repeat (3) wait_rise();
			chk_len(last_hi, rows[i].half);
			chk_len(last_lo, rows[i].half);
			chk_word(32'(min_len >= FAST_H), 32'h0000_0001);
			bus(1'b0, REG_STATUS, 32'h0000_0000);
			chk_word(32'(rd[STAT_SRC_FAST_BIT]), 32'(rows[i].fast));
		end
		// disable at the start of a slow low phase
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		bus(1'b1, REG_CTRL, 32'h0000_0000);
		wait_lvl(1'b1);
		@(posedge sys_clk);
		chk_len(last_lo, SLOW_H);
		repeat (2) @(posedge sys_clk);
		chk_rst(1'b1);
		n = 0;
		repeat (3 * SLOW_H) begin
			@(posedge sys_clk);
			if (clk_v[0] !== 1'b1)
				n++;
		end
		chk_len(n, 0);
		bus(1'b1, REG_CTRL, 32'h0000_0001);
		wait_rise();
		chk_len(last_lo, SLOW_H);
		repeat (POR_C + 10) @(posedge sys_clk);
		chk_rst(1'b0);
		// dip one cycle short of the filter, then a real brownout
		supply_above_rise <= 1'b0;
		supply_below_fall <= 1'b1;
		repeat (DIP_C - 1) @(posedge sys_clk);
		supply_above_rise <= 1'b1;
		supply_below_fall <= 1'b0;
		repeat (5) @(posedge sys_clk);
		chk_rst(1'b0);
		supply_above_rise <= 1'b0;
		supply_below_fall <= 1'b1;
		repeat (DIP_C + 3) @(posedge sys_clk);
		chk_rst(1'b1);
		supply_above_rise <= 1'b1;
		supply_below_fall <= 1'b0;
		t0 = $time;
		wait_release();
		conclude();
	end
endmodule // dsc_clock_reset_tb

// File: verification/dsc_mcu_model.sv
// model of the microcontroller clock input, measuring phase lengths
`timescale 1ns/1ns
module dsc_mcu_model (
	// clock
	input wire logic sys_clk,
	// observed clock pin and measurement clear
	input wire logic clk_in,
	input wire logic clr,
	// measured phase lengths in system cycles
	output int last_hi,
	output int last_lo,
	output int min_len
);
	logic prev_r;
	int cnt_r;

	initial begin
		prev_r = 1'b0;
		cnt_r = 0;
		last_hi = 0;
		last_lo = 0;
		min_len = 1_000_000;
	end

	// speed may move at any time, so every phase is measured
	always @(posedge sys_clk) begin
		if (clk_in !== prev_r) begin
			if (prev_r)
				last_hi <= cnt_r;
			else
				last_lo <= cnt_r;
			if (!clr && cnt_r < min_len)
				min_len <= cnt_r;
			cnt_r <= 1;
		end else begin
			cnt_r <= cnt_r + 1;
		end
		if (clr)
			min_len <= 1_000_000;
		prev_r <= clk_in;
	end
endmodule // dsc_mcu_model
